/* common/adc_port_pkg.sv */
package adc_port_pkg;
	// ==========================================
	// Clocking and conversion timing
	localparam int CLK_HZ = 100_000_000;
	localparam int OSC_HZ = 32768;
	localparam int CONV_PER_SEC = 16;
	localparam int CONV_TICKS = OSC_HZ / CONV_PER_SEC;
	localparam int OSC_DIV = CLK_HZ / OSC_HZ;
	localparam int INT_TICKS_60 = 545;
	localparam int INT_TICKS_50 = 655;
	localparam int CNT_W = 12;
	// ==========================================
	// Command register 0 and 1 fields
	localparam int START_BIT = 7;
	localparam int RATE_BIT = 6;
	localparam int SLEEP_BIT = 5;
	localparam int ZERO_BIT = 4;
	localparam int RS_LO_BIT = 2;
	localparam int RS_HI_BIT = 1;
	localparam int REG_SEL_BIT = 0;
	localparam int P_OUT_LSB = 4;
	localparam logic [7:0] INVALID_BYTE = 8'h00;
	// ==========================================
	// Register map
	localparam logic [11:0] ADDR_RESULT_IN = 12'h000;
	localparam logic [11:0] ADDR_CMD_VIEW = 12'h004;
	localparam logic [11:0] ADDR_IRQ_STATUS = 12'h008;
	localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h00c;
	localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h010;
	localparam logic [19:0] RESULT_IN_RST = 20'h00000;
	localparam int IRQ_W = 3;
	localparam int IRQ_COMMIT = 0;
	localparam int IRQ_DONE = 1;
	localparam int IRQ_COLL = 2;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {
		RB_LOW = 2'b00,
		RB_HIGH = 2'b01,
		RB_STATUS = 2'b10,
		RB_INVALID = 2'b11
	} readback_t;
	typedef enum logic [1:0] {
		CV_IDLE = 2'b00,
		CV_INTEG = 2'b01,
		CV_DEINT = 2'b10
	} conv_state_t;
endpackage

/* common/conv_if.sv */
`timescale 1ns/1ns
interface conv_if;
	logic [7:0] cmd0;
	logic [7:0] cmd1;
	logic commit;
	logic start_ack;
	logic done;
	logic coll_evt;
	logic collision;
	logic eoc;
	logic integrating;
	logic [18:0] result;
	logic neg;
	logic [19:0] result_in;
	modport link (output cmd0, cmd1, commit,
		input start_ack, collision, eoc, integrating, result, neg);
	modport conv (input cmd0, commit, result_in,
		output start_ack, done, coll_evt, collision, eoc, integrating, result, neg);
	modport top (input cmd0, cmd1, commit, done, coll_evt, eoc, integrating,
		output result_in);
endinterface

/* rtl/adc_serial_command_port.sv */
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
module adc_serial_command_port import adc_port_pkg::*; #(
	parameter int OSC_DIVIDE = OSC_DIV // System clocks per oscillator period
) (
	input wire logic clock, // System clock
	input wire logic sys_rst, // Synchronous reset
	input wire logic [11:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [11:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic cs_n_pin, // Link select, active low
	input wire logic sclk_pin, // Link shift clock
	input wire logic din_pin, // Link data in
	output logic dout, // Link data out
	output logic dout_oe, // Link data out enable
	output logic [3:0] p_out, // User outputs from command register 1
	output logic eoc, // End of conversion level
	output logic irq // Interrupt, active high level
);
	typedef struct packed {
		logic awready;
		logic aw_held;
		logic [11:0] awaddr;
		logic wready;
		logic w_held;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [19:0] result_in;
		logic [IRQ_W-1:0] irq_status;
		logic [IRQ_W-1:0] irq_en;
		logic irq;
		logic [3:0] p_out;
		logic eoc;
	} top_t;
	top_t r_reg, r_next;
	conv_if bus ();
	logic [IRQ_W-1:0] events;

	function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] st);
		apply_strb = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				apply_strb[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
	endfunction

	link_shifter u_link (
		.clock(clock),
		.sys_rst(sys_rst),
		.cs_n_pin(cs_n_pin),
		.sclk_pin(sclk_pin),
		.din_pin(din_pin),
		.dout(dout),
		.dout_oe(dout_oe),
		.bus(bus.link)
	);

	conv_sequencer #(.OSC_DIVIDE(OSC_DIVIDE)) u_conv (
		.clock(clock),
		.sys_rst(sys_rst),
		.bus(bus.conv)
	);

	assign bus.result_in = r_reg.result_in;
	assign events = {bus.coll_evt, bus.done, bus.commit};

	// ==========================================
	// Register bus and interrupts
	always_comb begin
		logic [IRQ_W-1:0] clr;
		logic [31:0] tmp;
		clr = '0;
		tmp = '0;
		r_next = r_reg;
		if (r_reg.awready && s_axi_awvalid) begin
			r_next.aw_held = 1'b1;
			r_next.awaddr = s_axi_awaddr;
		end
		if (r_reg.wready && s_axi_wvalid) begin
			r_next.w_held = 1'b1;
			r_next.wdata = s_axi_wdata;
			r_next.wstrb = s_axi_wstrb;
		end
		if (r_reg.bvalid && s_axi_bready) begin
			r_next.bvalid = 1'b0;
		end
		if (r_reg.aw_held && r_reg.w_held && !r_reg.bvalid) begin
			r_next.aw_held = 1'b0;
			r_next.w_held = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp = RESP_OKAY;
			if (r_reg.awaddr == ADDR_RESULT_IN) begin
				tmp = apply_strb({12'h000, r_reg.result_in}, r_reg.wdata, r_reg.wstrb);
				r_next.result_in = tmp[19:0];
			end else if (r_reg.awaddr == ADDR_IRQ_CLEAR) begin
				tmp = apply_strb(32'h00000000, r_reg.wdata, r_reg.wstrb);
				clr = tmp[IRQ_W-1:0];
			end else if (r_reg.awaddr == ADDR_IRQ_ENABLE) begin
				tmp = apply_strb({29'h0, r_reg.irq_en}, r_reg.wdata, r_reg.wstrb);
				r_next.irq_en = tmp[IRQ_W-1:0];
			end else if (r_reg.awaddr == ADDR_CMD_VIEW || r_reg.awaddr == ADDR_IRQ_STATUS) begin
				r_next.bresp = RESP_OKAY;
			end else begin
				r_next.bresp = RESP_SLVERR;
			end
		end
		r_next.awready = !r_next.aw_held && !r_next.bvalid;
		r_next.wready = !r_next.w_held && !r_next.bvalid;
		if (r_reg.arready && s_axi_arvalid) begin
			r_next.rvalid = 1'b1;
			r_next.rresp = RESP_OKAY;
			if (s_axi_araddr == ADDR_RESULT_IN) begin
				r_next.rdata = {12'h000, r_reg.result_in};
			end else if (s_axi_araddr == ADDR_CMD_VIEW) begin
				r_next.rdata = {14'h0000, bus.integrating, bus.eoc, bus.cmd1, bus.cmd0};
			end else if (s_axi_araddr == ADDR_IRQ_STATUS) begin
				r_next.rdata = {29'h0, r_reg.irq_status};
			end else if (s_axi_araddr == ADDR_IRQ_ENABLE) begin
				r_next.rdata = {29'h0, r_reg.irq_en};
			end else if (s_axi_araddr == ADDR_IRQ_CLEAR) begin
				r_next.rdata = 32'h00000000;
			end else begin
				r_next.rdata = 32'h00000000;
				r_next.rresp = RESP_SLVERR;
			end
		end else if (r_reg.rvalid && s_axi_rready) begin
			r_next.rvalid = 1'b0;
		end
		r_next.arready = !r_next.rvalid;
		// A new event wins over a clear in the same cycle
		r_next.irq_status = (r_reg.irq_status & ~clr) | events;
		r_next.irq = |(r_next.irq_status & r_next.irq_en);
		r_next.p_out = bus.cmd1[7:P_OUT_LSB];
		r_next.eoc = bus.eoc;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			r_reg <= '{result_in: RESULT_IN_RST, default: '0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign s_axi_awready = r_reg.awready;
	assign s_axi_wready = r_reg.wready;
	assign s_axi_bresp = r_reg.bresp;
	assign s_axi_bvalid = r_reg.bvalid;
	assign s_axi_arready = r_reg.arready;
	assign s_axi_rdata = r_reg.rdata;
	assign s_axi_rresp = r_reg.rresp;
	assign s_axi_rvalid = r_reg.rvalid;
	assign p_out = r_reg.p_out;
	assign eoc = r_reg.eoc;
	assign irq = r_reg.irq;

	// ==========================================
	// Assertions
	sequence s_write_ready;
		r_reg.aw_held && r_reg.w_held && !r_reg.bvalid;
	endsequence
	property p_write_resp;
		@(posedge clock) disable iff (sys_rst) s_write_ready |=> r_reg.bvalid;
	endproperty
	a_write_resp: assert property (p_write_resp) else $error("no write response");
	property p_b_hold;
		@(posedge clock) disable iff (sys_rst) r_reg.bvalid && !s_axi_bready |=> r_reg.bvalid;
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
	property p_done_irq;
		@(posedge clock) disable iff (sys_rst) bus.done && r_reg.irq_en[IRQ_DONE] |=>
			r_reg.irq && r_reg.irq_status[IRQ_DONE];
	endproperty
	a_done_irq: assert property (p_done_irq) else $error("done irq missing");
	property p_commit_p_out;
		@(posedge clock) disable iff (sys_rst) bus.commit |=> r_reg.p_out == bus.cmd1[7:4];
	endproperty
	a_commit_p_out: assert property (p_commit_p_out) else $error("p_out stale");

	// ==========================================
	// Address map and bus handshakes
	function automatic logic mapped(input logic [11:0] a);
		mapped = a == ADDR_RESULT_IN || a == ADDR_CMD_VIEW || a == ADDR_IRQ_STATUS ||
			a == ADDR_IRQ_CLEAR || a == ADDR_IRQ_ENABLE;
	endfunction
	sequence s_write_bad;
		r_reg.aw_held && r_reg.w_held && !r_reg.bvalid && !mapped(r_reg.awaddr);
	endsequence
	sequence s_read_bad;
		r_reg.arready && s_axi_arvalid && !mapped(s_axi_araddr);
	endsequence
	property p_read_resp;
		@(posedge clock) disable iff (sys_rst) r_reg.arready && s_axi_arvalid |=> r_reg.rvalid;
	endproperty
	a_read_resp: assert property (p_read_resp) else $error("no read response");
	property p_r_hold;
		@(posedge clock) disable iff (sys_rst) r_reg.rvalid && !s_axi_rready |=>
			r_reg.rvalid && $stable(r_reg.rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_ar_block;
		@(posedge clock) disable iff (sys_rst) r_reg.rvalid |-> !r_reg.arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("arready during rvalid");
	property p_aw_block;
		@(posedge clock) disable iff (sys_rst) r_reg.bvalid |-> !r_reg.awready && !r_reg.wready;
	endproperty
	a_aw_block: assert property (p_aw_block) else $error("ready during bvalid");
	property p_aw_held_block;
		@(posedge clock) disable iff (sys_rst) r_reg.aw_held |-> !r_reg.awready;
	endproperty
	a_aw_held_block: assert property (p_aw_held_block) else $error("awready while held");
	property p_w_held_block;
		@(posedge clock) disable iff (sys_rst) r_reg.w_held |-> !r_reg.wready;
	endproperty
	a_w_held_block: assert property (p_w_held_block) else $error("wready while held");
	property p_bad_write;
		@(posedge clock) disable iff (sys_rst) s_write_bad |=> r_reg.bresp == RESP_SLVERR;
	endproperty
	a_bad_write: assert property (p_bad_write) else $error("unmapped write not refused");
	property p_bad_read;
		@(posedge clock) disable iff (sys_rst) s_read_bad |=>
			r_reg.rvalid && r_reg.rresp == RESP_SLVERR && r_reg.rdata == '0;
	endproperty
	a_bad_read: assert property (p_bad_read) else $error("unmapped read not refused");
	property p_result_write;
		@(posedge clock) disable iff (sys_rst) r_reg.aw_held && r_reg.w_held && !r_reg.bvalid &&
			r_reg.awaddr == ADDR_RESULT_IN && r_reg.wstrb == 4'hf |=>
			r_reg.result_in == r_reg.wdata[19:0];
	endproperty
	a_result_write: assert property (p_result_write) else $error("result write lost");
	property p_enable_write;
		@(posedge clock) disable iff (sys_rst) r_reg.aw_held && r_reg.w_held && !r_reg.bvalid &&
			r_reg.awaddr == ADDR_IRQ_ENABLE && r_reg.wstrb[0] |=>
			r_reg.irq_en == r_reg.wdata[IRQ_W-1:0];
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable write lost");

	// ==========================================
	// Interrupt status and level
	property p_irq_level;
		@(posedge clock) disable iff (sys_rst) r_reg.irq == |(r_reg.irq_status & r_reg.irq_en);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq level wrong");
	property p_commit_sticky;
		@(posedge clock) disable iff (sys_rst) bus.commit |=> r_reg.irq_status[IRQ_COMMIT];
	endproperty
	a_commit_sticky: assert property (p_commit_sticky) else $error("commit lost");
	property p_coll_sticky;
		@(posedge clock) disable iff (sys_rst) bus.coll_evt |=> r_reg.irq_status[IRQ_COLL];
	endproperty
	a_coll_sticky: assert property (p_coll_sticky) else $error("collision lost");
	property p_clear;
		@(posedge clock) disable iff (sys_rst) r_reg.aw_held && r_reg.w_held && !r_reg.bvalid &&
			r_reg.awaddr == ADDR_IRQ_CLEAR && r_reg.wstrb[0] && !(|events) |=>
			(r_reg.irq_status & r_reg.wdata[IRQ_W-1:0]) == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("clear ignored");
endmodule

/* rtl/conv_sequencer.sv */
`timescale 1ns/1ns
module conv_sequencer import adc_port_pkg::*; #(
	parameter int OSC_DIVIDE = OSC_DIV // System clocks per oscillator period
) (
	input wire logic clock, // System clock
	input wire logic sys_rst, // Synchronous reset
	conv_if.conv bus // Command and status exchange
);
	localparam logic [CNT_W-1:0] DIV_LAST = CNT_W'(OSC_DIVIDE - 1);
	localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_TICKS - 1);
	typedef struct packed {
		conv_state_t state;
		logic [CNT_W-1:0] div_cnt;
		logic [CNT_W-1:0] conv_cnt;
		logic tick;
		logic rate_50;
		logic [19:0] sample;
		logic [18:0] result;
		logic neg;
		logic eoc;
		logic collision;
		logic coll_evt;
		logic start_ack;
		logic done;
	} seq_t;
	seq_t r_reg, r_next;

	function automatic logic [CNT_W-1:0] int_len(input logic rate_50);
		int_len = rate_50 ? CNT_W'(INT_TICKS_50) : CNT_W'(INT_TICKS_60);
	endfunction

	always_comb begin
		r_next = r_reg;
		r_next.tick = 1'b0;
		r_next.start_ack = 1'b0;
		r_next.done = 1'b0;
		r_next.coll_evt = 1'b0;
		// Oscillator period derived from the system clock
		if (r_reg.div_cnt == DIV_LAST) begin
			r_next.div_cnt = '0;
			r_next.tick = 1'b1;
		end else begin
			r_next.div_cnt = r_reg.div_cnt + 1'b1;
		end
		if (bus.commit && bus.cmd0[START_BIT] && r_reg.state != CV_IDLE) begin
			r_next.collision = 1'b1;
			r_next.coll_evt = 1'b1;
		end
		if (r_reg.tick) begin
			case (r_reg.state)
				CV_IDLE: begin
					if (bus.cmd0[START_BIT]) begin
						r_next.state = CV_INTEG;
						r_next.conv_cnt = CNT_W'(1);
						r_next.start_ack = 1'b1;
						r_next.eoc = 1'b0;
						r_next.collision = 1'b0;
						r_next.rate_50 = bus.cmd0[RATE_BIT];
						r_next.sample = bus.cmd0[ZERO_BIT] ? '0 : bus.result_in;
					end
				end
				CV_INTEG: begin
					r_next.conv_cnt = r_reg.conv_cnt + 1'b1;
					if (r_reg.conv_cnt == int_len(r_reg.rate_50)) begin
						r_next.state = CV_DEINT;
					end
				end
				CV_DEINT: begin
					if (r_reg.conv_cnt == CONV_LAST) begin
						r_next.conv_cnt = '0;
						r_next.state = CV_IDLE;
						r_next.eoc = 1'b1;
						r_next.done = 1'b1;
						r_next.result = r_reg.sample[18:0];
						r_next.neg = r_reg.sample[19];
					end else begin
						r_next.conv_cnt = r_reg.conv_cnt + 1'b1;
					end
				end
				default: r_next.state = CV_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			r_reg <= '{state: CV_IDLE, eoc: 1'b1, default: '0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign bus.start_ack = r_reg.start_ack;
	assign bus.done = r_reg.done;
	assign bus.coll_evt = r_reg.coll_evt;
	assign bus.collision = r_reg.collision;
	assign bus.eoc = r_reg.eoc;
	assign bus.integrating = (r_reg.state == CV_INTEG);
	assign bus.result = r_reg.result;
	assign bus.neg = r_reg.neg;

	// ==========================================
	// Assertions
	property p_int_length;
		@(posedge clock) disable iff (sys_rst) $rose(r_reg.state == CV_DEINT) |->
			r_reg.conv_cnt == int_len(r_reg.rate_50) + 1'b1;
	endproperty
	a_int_length: assert property (p_int_length) else $error("integration length");
	property p_eoc_idle;
		@(posedge clock) disable iff (sys_rst) r_reg.eoc == (r_reg.state == CV_IDLE);
	endproperty
	a_eoc_idle: assert property (p_eoc_idle) else $error("eoc mismatch");
	property p_start;
		@(posedge clock) disable iff (sys_rst) r_reg.start_ack |->
			r_reg.state == CV_INTEG && r_reg.conv_cnt == CNT_W'(1) && !r_reg.eoc;
	endproperty
	a_start: assert property (p_start) else $error("start not taken");
endmodule

/* rtl/link_shifter.sv */
`timescale 1ns/1ns
module link_shifter import adc_port_pkg::*; (
	input wire logic clock, // System clock
	input wire logic sys_rst, // Synchronous reset
	input wire logic cs_n_pin, // Select, active low
	input wire logic sclk_pin, // Shift clock from host
	input wire logic din_pin, // Serial data in
	output logic dout, // Serial data out
	output logic dout_oe, // Serial data out enable
	conv_if.link bus // Command and status exchange
);
	typedef struct packed {
		logic cs_s1, cs_s2, cs_d;
		logic sclk_s1, sclk_s2, sclk_d;
		logic din_s1, din_s2;
		logic [7:0] shift_in;
		logic [7:0] shift_out;
		logic [7:0] cmd0;
		logic [7:0] cmd1;
		logic commit;
		logic dout;
		logic dout_oe;
	} link_t;
	link_t r_reg, r_next;
	logic [7:0] sel_byte;
	logic cs_fall, cs_rise, sclk_rise, sclk_fall;

	function automatic logic [7:0] out_byte(input logic [7:0] c0, input logic [18:0] res,
		input logic ng, input logic col, input logic eo, input logic integ);
		readback_t code;
		code = readback_t'({c0[RS_HI_BIT], c0[RS_LO_BIT]});
		case (code)
			RB_LOW: out_byte = res[10:3];
			RB_HIGH: out_byte = res[18:11];
			RB_STATUS: out_byte = {col, eo, integ, c0[SLEEP_BIT], ng, res[2:0]};
			default: out_byte = INVALID_BYTE;
		endcase
	endfunction

	assign cs_fall = r_reg.cs_d & ~r_reg.cs_s2;
	assign cs_rise = ~r_reg.cs_d & r_reg.cs_s2;
	assign sclk_rise = ~r_reg.sclk_d & r_reg.sclk_s2;
	assign sclk_fall = r_reg.sclk_d & ~r_reg.sclk_s2;
	// Readback choice uses cmd0 committed by the last frame with the register select bit clear
	assign sel_byte = out_byte(r_reg.cmd0, bus.result, bus.neg, bus.collision, bus.eoc,
		bus.integrating);

	always_comb begin
		r_next = r_reg;
		r_next.cs_s1 = cs_n_pin;
		r_next.cs_s2 = r_reg.cs_s1;
		r_next.cs_d = r_reg.cs_s2;
		r_next.sclk_s1 = sclk_pin;
		r_next.sclk_s2 = r_reg.sclk_s1;
		r_next.sclk_d = r_reg.sclk_s2;
		r_next.din_s1 = din_pin;
		r_next.din_s2 = r_reg.din_s1;
		r_next.commit = 1'b0;
		r_next.dout_oe = ~r_reg.cs_s2;
		if (bus.start_ack) begin
			r_next.cmd0[START_BIT] = 1'b0;
		end
		if (!r_reg.cs_s2) begin
			if (sclk_rise) begin
				r_next.shift_in = {r_reg.shift_in[6:0], r_reg.din_s2};
			end
			if (sclk_fall) begin
				r_next.dout = r_reg.shift_out[7];
				r_next.shift_out = {r_reg.shift_out[6:0], 1'b0};
			end
		end
		if (cs_fall) begin
			r_next.dout = sel_byte[7];
			r_next.shift_out = {sel_byte[6:0], 1'b0};
		end
		if (cs_rise) begin
			r_next.commit = 1'b1;
			if (r_reg.shift_in[REG_SEL_BIT]) begin
				r_next.cmd1 = r_reg.shift_in;
			end else begin
				r_next.cmd0 = r_reg.shift_in;
			end
		end
		if (!r_next.dout_oe) begin
			r_next.dout = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			r_reg <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_d: 1'b1, default: '0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign dout = r_reg.dout;
	assign dout_oe = r_reg.dout_oe;
	assign bus.cmd0 = r_reg.cmd0;
	assign bus.cmd1 = r_reg.cmd1;
	assign bus.commit = r_reg.commit;

	// ==========================================
	// Assertions
	sequence s_cs_rise;
		~r_reg.cs_d && r_reg.cs_s2;
	endsequence
	property p_commit_on_rise;
		@(posedge clock) disable iff (sys_rst) s_cs_rise |=> r_reg.commit;
	endproperty
	a_commit_on_rise: assert property (p_commit_on_rise) else $error("no commit");
	property p_route;
		@(posedge clock) disable iff (sys_rst) s_cs_rise ##1 r_reg.commit |->
			(r_reg.shift_in[REG_SEL_BIT] ? r_reg.cmd1 == r_reg.shift_in :
			r_reg.cmd0[6:0] == r_reg.shift_in[6:0]);
	endproperty
	a_route: assert property (p_route) else $error("wrong command register");
	property p_oe_follows_cs;
		@(posedge clock) disable iff (sys_rst) ##1 r_reg.dout_oe == !$past(r_reg.cs_s2);
	endproperty
	a_oe_follows_cs: assert property (p_oe_follows_cs) else $error("oe wrong");
	property p_msb_first;
		@(posedge clock) disable iff (sys_rst) (r_reg.cs_d && ~r_reg.cs_s2) |=>
			r_reg.dout == $past(sel_byte[7]);
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("first bit not msb");
endmodule

/* sim/adc_serial_command_port_test.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module adc_serial_command_port_test import adc_port_pkg::*;;
	localparam int DIV = 4;
	localparam logic [19:0] RES = 20'h2b3c5;
	logic clock, sys_rst, cs_n_pin, sclk_pin, din_pin, dout, dout_oe, eoc, irq;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, p_out;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int n_mismatch, n_checks;
	// ==========================================
	// Device and host
	adc_serial_command_port #(.OSC_DIVIDE(DIV)) adc_serial_command_port_inst (.clock, .sys_rst,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .cs_n_pin, .sclk_pin, .din_pin, .dout, .dout_oe,
		.p_out, .eoc, .irq);
	link_host link_host_inst (.clock, .cs_n_pin, .sclk_pin, .din_pin, .dout, .dout_oe);
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// ==========================================
	// Register bus tasks
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int k;
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (k = 0; k < 50 && (aw || w); k++) begin
			@(negedge clock);
			if (s_axi_awready) aw = 1'b0;
			if (s_axi_wready) w = 1'b0;
			@(posedge clock);
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
		end
		k = 0;
		do @(negedge clock); while (!s_axi_bvalid && ++k < 50);
		`CHK(s_axi_bvalid, 1'b1)
		`CHK(s_axi_bresp, er)
		@(posedge clock);
		s_axi_bready <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		int k;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		k = 0;
		do @(negedge clock); while (!s_axi_arready && ++k < 50);
		@(posedge clock);
		s_axi_arvalid <= 1'b0;
		do @(negedge clock); while (!s_axi_rvalid && ++k < 100);
		d = s_axi_rvalid ? s_axi_rdata : 32'hxxxxxxxx;
		@(posedge clock);
		s_axi_rready <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		rd(a, d);
		`CHK(d, e)
		`CHK(s_axi_rresp, er)
	endtask
	task automatic ci(input logic e);
		repeat (3) @(negedge clock);
		`CHK(irq, e)
		@(posedge clock);
	endtask
	// ==========================================
	// Scenarios
	task automatic t_reset();
		`CHK({dout_oe, p_out, irq, eoc}, 7'h01)
		rc(ADDR_CMD_VIEW, 32'h00010000, RESP_OKAY);
		rc(12'h014, 32'h00000000, RESP_SLVERR);
		rc(ADDR_IRQ_CLEAR, 32'h00000000, RESP_OKAY);
		wr(12'h020, 32'h0000000f, RESP_SLVERR);
	endtask
	task automatic t_cmd1();
		logic [7:0] rx;
		link_host_inst.frame(8'ha1, rx);
		`CHK(rx, 8'h00)
		`CHK(p_out, 4'ha)
		`CHK(dout_oe, 1'b0)
		rc(ADDR_CMD_VIEW, 32'h0001a100, RESP_OKAY);
	endtask
	task automatic t_conv(input logic [7:0] c, input int ticks);
		logic [7:0] rx;
		logic [31:0] d;
		time t1, t0;
		int k;
		link_host_inst.frame(c, rx);
		k = 0;
		do @(negedge clock); while (eoc && ++k < 100);
		t0 = $time;
		@(posedge clock);
		do rd(ADDR_CMD_VIEW, d); while (d[17] === 1'b1 && ++k < 3000);
		t1 = $time - t0;
		`CHK(t1 > ticks * DIV * 10 - 150 && t1 < ticks * DIV * 10 + 150, 1'b1)
		do @(negedge clock); while (!eoc && ++k < 20000);
		t1 = $time - t0;
		`CHK(t1 > CONV_TICKS * DIV * 10 - 150 && t1 < CONV_TICKS * DIV * 10 + 150, 1'b1)
		@(posedge clock);
	endtask
	task automatic t_readback();
		logic [7:0] rx;
		logic [7:0] cmd [4];
		logic [7:0] ex [4];
		int i;
		cmd = '{8'h04, 8'h02, 8'h06, 8'h00};
		ex = '{RES[10:3], RES[18:11], {4'b0100, RES[19], RES[2:0]}, INVALID_BYTE};
		for (i = 0; i < 4; i++) begin
			link_host_inst.frame(cmd[i], rx);
			`CHK(rx, ex[i])
		end
	endtask
	task automatic t_irq();
		logic [7:0] rx;
		rc(ADDR_IRQ_STATUS, 32'h00000003, RESP_OKAY);
		ci(1'b0);
		wr(ADDR_IRQ_ENABLE, 32'h00000002, RESP_OKAY);
		ci(1'b1);
		wr(ADDR_IRQ_CLEAR, 32'h00000007, RESP_OKAY);
		ci(1'b0);
		rc(ADDR_IRQ_STATUS, 32'h00000000, RESP_OKAY);
		wr(ADDR_IRQ_ENABLE, 32'h00000001, RESP_OKAY);
		link_host_inst.frame(8'h51, rx);
		ci(1'b1);
		`CHK(p_out, 4'h5)
		rc(ADDR_CMD_VIEW, 32'h00015100, RESP_OKAY);
	endtask
	// ==========================================
	// Verdict, watchdog and main sequence
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clock);
		n_mismatch++;
		print_verdict();
	end
	initial begin
		n_mismatch = 0;
		n_checks = 0;
		sys_rst = 1'b1;
		s_axi_awaddr = 12'h000;
		s_axi_araddr = 12'h000;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		repeat (10) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (6) @(posedge clock);
		t_reset();
		t_cmd1();
		wr(ADDR_RESULT_IN, {12'h000, RES}, RESP_OKAY);
		t_conv(8'h80, INT_TICKS_60);
		t_conv(8'hc0, INT_TICKS_50);
		t_readback();
		t_irq();
		print_verdict();
	end
endmodule

/* sim/link_host.sv */
`timescale 1ns/1ns
module link_host (
	input wire logic clock, // System clock that paces the host
	output logic cs_n_pin, // Select, active low
	output logic sclk_pin, // Shift clock, 80 ns period
	output logic din_pin, // Command data to device
	input wire logic dout, // Data from device
	input wire logic dout_oe // Device drives dout
);
	initial begin
		cs_n_pin = 1'b1;
		sclk_pin = 1'b0;
		din_pin = 1'b0;
	end
	// ==========================================
	// One full-duplex frame; shift clock stands low outside frames
	task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
		int i;
		repeat (100) @(posedge clock);
		cs_n_pin <= 1'b0;
		repeat (6) @(posedge clock);
		for (i = 7; i >= 0; i--) begin
			din_pin <= tx[i];
			repeat (4) @(posedge clock);
			sclk_pin <= 1'b1;
			@(negedge clock);
			rx[i] = dout_oe ? dout : 1'bx;
			repeat (4) @(posedge clock);
			sclk_pin <= 1'b0;
		end
		repeat (4) @(posedge clock);
		cs_n_pin <= 1'b1;
		// Released line has no pull: show the inverse of the last bit
		din_pin <= ~tx[0];
		repeat (8) @(posedge clock);
	endtask
endmodule
